// file: core/tcam_block.v
// Ternary content-addressable memory block with selectable register
// timing, mask register and register port for configuration.
// Assumes user logic on core_clk drives the data inputs; global clock
// nets arrive asynchronously and are used only as rate enables.
//
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
`include "tcam_map.vh"

module tcam_block (
	// Clock and reset
	input  wire                   core_clk,
	input  wire                   rst_n,
	// Global clock nets and local reset
	input  wire [3:0]             global_clock_nets,
	input  wire                   loc_rst,
	// Compare and update inputs
	input  wire [`TCAM_WIDTH-1:0] cmp_wr_data,
	input  wire [`TCAM_AW-1:0]    wr_addr,
	input  wire                   wr_en,
	input  wire                   wr_sel,
	input  wire                   dont_care_wr,
	input  wire                   mask_en,
	// Match outputs
	output reg                    match_flag,
	output reg                    multi_match,
	output reg  [`TCAM_AW-1:0]    match_addr,
	output reg                    match_valid,
	// Register port
	input  wire [7:0]             reg_addr,
	input  wire [31:0]            reg_wdata,
	input  wire                   reg_wr,
	input  wire                   reg_rd,
	output reg  [31:0]            reg_rdata
);

	// ------------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------------

	// Picks the clock tick from the local clock or a global net edge
	function clk_tick;
		input [2:0] src;
		input       inv;
		input [3:0] rise;
		input [3:0] fall;
		begin
			if (src == `TCAM_SRC_LOCAL)
				clk_tick = 1'b1;
			else if (src > 3'h4)
				clk_tick = 1'b0;
			else if (inv)
				clk_tick = fall[src[1:0] - 2'h1];
			else
				clk_tick = rise[src[1:0] - 2'h1];
		end
	endfunction

	// Picks the clock enable from write enable or nets one and two
	function en_pick;
		input [1:0] src;
		input       inv;
		input       we;
		input [3:0] lvl;
		reg         raw;
		begin
			case (src)
				`TCAM_EN_LOCAL: raw = we;
				`TCAM_EN_NET1:  raw = lvl[1];
				`TCAM_EN_NET2:  raw = lvl[2];
				default:        raw = 1'b0;
			endcase
			en_pick = raw ^ inv;
		end
	endfunction

	// ------------------------------------------------------------------
	// Reset synchroniser
	// ------------------------------------------------------------------

	reg rst_meta_n;
	reg rst_sync_n;

	// Release reset through two flops
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_n <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta_n <= 1'b1;
			rst_sync_n <= rst_meta_n;
		end
	end

	// ------------------------------------------------------------------
	// Global net synchronisers and edge detect
	// ------------------------------------------------------------------

	reg  [3:0] net_meta;
	reg  [3:0] net_sync;
	reg  [3:0] net_last;
	reg  [1:0] net_age;
	wire [3:0] net_rise;
	wire [3:0] net_fall;

	// Two flops, then a third copy for edges
	always @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			net_meta <= 4'h0;
			net_sync <= 4'h0;
			net_last <= 4'h0;
			net_age  <= 2'h0;
		end else begin
			net_meta <= global_clock_nets;
			net_sync <= net_meta;
			net_last <= net_sync;
			net_age  <= net_age + {1'b0, ~&net_age};
		end
	end

	assign net_rise = {4{&net_age}} & net_sync & ~net_last; // No reset edge
	assign net_fall = {4{&net_age}} & ~net_sync & net_last;

	// ------------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------------

	reg [1:0]             ctrl;
	reg [7:0]             iclk_cfg;
	reg [7:0]             oclk_cfg;
	reg [`TCAM_WIDTH-1:0] mask_reg;

	// Software writes to configuration
	always @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			ctrl     <= `TCAM_CTRL_RST;
			iclk_cfg <= `TCAM_CLK_RST;
			oclk_cfg <= `TCAM_CLK_RST;
			mask_reg <= `TCAM_MASK_RST;
		end else if (reg_wr) begin
			case (reg_addr)
				`TCAM_REG_CTRL:    ctrl <= reg_wdata[1:0];
				`TCAM_REG_ICLK:    iclk_cfg <= reg_wdata[7:0];
				`TCAM_REG_OCLK:    oclk_cfg <= reg_wdata[7:0];
				`TCAM_REG_MASK_LO: mask_reg[31:0] <= reg_wdata;
				`TCAM_REG_MASK_HI: mask_reg[47:32] <= reg_wdata[15:0];
				default:           ctrl <= ctrl;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Effective reset, clock ticks and enables
	// ------------------------------------------------------------------

	wire loc_rst_act;
	wire in_fire;
	wire out_fire;

	// Local reset term, optionally inverted, joins the global one
	assign loc_rst_act = loc_rst ^ ctrl[`TCAM_CTRL_LRINV];

	// One tick and one enable shared by every input register
	assign in_fire = clk_tick(iclk_cfg[`TCAM_CLK_SRC_HI:`TCAM_CLK_SRC_LO],
		iclk_cfg[`TCAM_CLK_INV], net_rise, net_fall)
		& en_pick(iclk_cfg[`TCAM_EN_SRC_HI:`TCAM_EN_SRC_LO],
		iclk_cfg[`TCAM_EN_INV], wr_en, net_sync);

	// One tick and one enable shared by every output register
	assign out_fire = clk_tick(oclk_cfg[`TCAM_CLK_SRC_HI:`TCAM_CLK_SRC_LO],
		oclk_cfg[`TCAM_CLK_INV], net_rise, net_fall)
		& en_pick(oclk_cfg[`TCAM_EN_SRC_HI:`TCAM_EN_SRC_LO],
		oclk_cfg[`TCAM_EN_INV], wr_en, net_sync);

	// ------------------------------------------------------------------
	// Input capture registers
	// ------------------------------------------------------------------

	reg [`TCAM_WIDTH-1:0] cap_data;
	reg [`TCAM_AW-1:0]    cap_addr;
	reg                   cap_we;
	reg                   cap_sel;
	reg                   cap_dc;
	reg                   cap_new;

	// Sample the data group on the selected input tick
	always @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			cap_data <= {`TCAM_WIDTH{1'b0}};
			cap_addr <= {`TCAM_AW{1'b0}};
			cap_we   <= 1'b0;
			cap_sel  <= 1'b0;
			cap_dc   <= 1'b0;
			cap_new  <= 1'b0;
		end else if (loc_rst_act) begin
			cap_data <= {`TCAM_WIDTH{1'b0}};
			cap_addr <= {`TCAM_AW{1'b0}};
			cap_we   <= 1'b0;
			cap_sel  <= 1'b0;
			cap_dc   <= 1'b0;
			cap_new  <= 1'b0;
		end else begin
			cap_new <= in_fire;
			if (in_fire) begin
				cap_data <= cmp_wr_data;
				cap_addr <= wr_addr;
				cap_we   <= wr_en;
				cap_sel  <= wr_sel;
				cap_dc   <= dont_care_wr;
			end
		end
	end

	// ------------------------------------------------------------------
	// Ternary storage
	// ------------------------------------------------------------------

	reg  [`TCAM_WIDTH-1:0] ent_val  [0:`TCAM_ENTRIES-1];
	reg  [`TCAM_WIDTH-1:0] ent_care [0:`TCAM_ENTRIES-1];
	wire [`TCAM_WIDTH-1:0] live_mask;
	wire                   do_write;
	wire [`TCAM_WIDTH-1:0] next_val;
	wire [`TCAM_WIDTH-1:0] next_care;

	// Mask applies only while the enable is held; it is used unlatched
	assign live_mask = mask_en ? mask_reg : {`TCAM_WIDTH{1'b0}};
	assign do_write  = cap_new & cap_we & cap_sel;

	// Masked bits keep their old content, others take data or don't-care
	assign next_val  = (ent_val[cap_addr] & live_mask)
		| ((cap_dc ? {`TCAM_WIDTH{1'b0}} : cap_data) & ~live_mask);
	assign next_care = (ent_care[cap_addr] & live_mask)
		| ({`TCAM_WIDTH{~cap_dc}} & ~live_mask);

	integer k;

	// Update writes one entry once per captured write
	always @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			for (k = 0; k < `TCAM_ENTRIES; k = k + 1) begin
				ent_val[k]  <= {`TCAM_WIDTH{1'b0}};
				ent_care[k] <= {`TCAM_WIDTH{1'b1}};
			end
		end else if (do_write) begin
			ent_val[cap_addr]  <= next_val;
			ent_care[cap_addr] <= next_care;
		end
	end

	// ------------------------------------------------------------------
	// Compare
	// ------------------------------------------------------------------

	reg  [`TCAM_ENTRIES-1:0] hit;
	wire                     any_hit;
	wire                     multi_hit;
	wire [`TCAM_AW-1:0]      low_addr;
	wire                     cmp_op;

	// A captured select without write enable is a compare
	assign cmp_op = cap_sel & ~cap_we;

	integer j;

	// Entry matches when every cared, unmasked bit equals the key
	always @* begin
		for (j = 0; j < `TCAM_ENTRIES; j = j + 1) begin
			hit[j] = cmp_op & (&(~(ent_val[j] ^ cap_data)
				| ~ent_care[j] | live_mask));
		end
	end

	tcam_prio_enc u_enc (
		.hit       (hit),
		.any_hit   (any_hit),
		.multi_hit (multi_hit),
		.low_addr  (low_addr)
	);

	// ------------------------------------------------------------------
	// Output registers
	// ------------------------------------------------------------------

	wire out_load;

	// Combinational mode follows every cycle, registered mode the tick
	assign out_load = ctrl[`TCAM_CTRL_COMB] | out_fire;

	// Result flags and address, cleared when nothing matches
	always @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			match_flag  <= 1'b0;
			multi_match <= 1'b0;
			match_addr  <= {`TCAM_AW{1'b0}};
			match_valid <= 1'b0;
		end else if (loc_rst_act) begin
			match_flag  <= 1'b0;
			multi_match <= 1'b0;
			match_addr  <= {`TCAM_AW{1'b0}};
			match_valid <= 1'b0;
		end else if (out_load) begin
			match_flag  <= any_hit;
			multi_match <= multi_hit;
			match_valid <= any_hit;
			match_addr  <= any_hit ? low_addr
				: {`TCAM_AW{1'b0}};
		end
	end

	// ------------------------------------------------------------------
	// Activity counters
	// ------------------------------------------------------------------

	reg [15:0] cmp_count;
	reg [15:0] wr_count;

	// Count completed compares and writes, wrapping
	always @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			cmp_count <= 16'h0000;
			wr_count  <= 16'h0000;
		end else begin
			if (cap_new & cmp_op)
				cmp_count <= cmp_count + 16'h0001;
			if (do_write)
				wr_count <= wr_count + 16'h0001;
		end
	end

	// ------------------------------------------------------------------
	// Register read port
	// ------------------------------------------------------------------

	reg [31:0] next_rdata;

	// Read decode; unmapped offsets read as zero
	always @* begin
		next_rdata = 32'h00000000;
		case (reg_addr)
			`TCAM_REG_CTRL:    next_rdata = {30'h00000000, ctrl};
			`TCAM_REG_ICLK:    next_rdata = {24'h000000, iclk_cfg};
			`TCAM_REG_OCLK:    next_rdata = {24'h000000, oclk_cfg};
			`TCAM_REG_MASK_LO: next_rdata = mask_reg[31:0];
			`TCAM_REG_MASK_HI: next_rdata = {16'h0000, mask_reg[47:32]};
			`TCAM_REG_STATUS: begin
				next_rdata[`TCAM_AW-1:0]   = match_addr;
				next_rdata[`TCAM_ST_MATCH] = match_flag;
				next_rdata[`TCAM_ST_MULTI] = multi_match;
				next_rdata[`TCAM_ST_VALID] = match_valid;
			end
			`TCAM_REG_COUNT:   next_rdata = {wr_count, cmp_count};
			default:           next_rdata = 32'h00000000;
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n)
			reg_rdata <= 32'h00000000;
		else if (reg_rd)
			reg_rdata <= next_rdata;
		else
			reg_rdata <= 32'h00000000;
	end

endmodule
`default_nettype wire

// file: core/tcam_map.vh
// Constants for the ternary match block: register offsets, field
// positions, reset values and array dimensions.
// Assumes it is included by bare name from files under core/.
`ifndef TCAM_MAP_VH
`define TCAM_MAP_VH

// ------------------------------------------------------------------
// Array dimensions
// ------------------------------------------------------------------
`define TCAM_ENTRIES      128
`define TCAM_WIDTH        48
`define TCAM_AW           7

// ------------------------------------------------------------------
// Register offsets (byte addresses)
// ------------------------------------------------------------------
`define TCAM_REG_CTRL     8'h00
`define TCAM_REG_ICLK     8'h04
`define TCAM_REG_OCLK     8'h08
`define TCAM_REG_MASK_LO  8'h0c
`define TCAM_REG_MASK_HI  8'h10
`define TCAM_REG_STATUS   8'h14
`define TCAM_REG_COUNT    8'h18

// ------------------------------------------------------------------
// Field positions
// ------------------------------------------------------------------
`define TCAM_CTRL_COMB    0
`define TCAM_CTRL_LRINV   1
`define TCAM_CLK_SRC_LO   0
`define TCAM_CLK_SRC_HI   2
`define TCAM_CLK_INV      3
`define TCAM_EN_SRC_LO    4
`define TCAM_EN_SRC_HI    5
`define TCAM_EN_INV       7
`define TCAM_ST_MATCH     8
`define TCAM_ST_MULTI     9
`define TCAM_ST_VALID     10

// ------------------------------------------------------------------
// Source encodings and reset values
// ------------------------------------------------------------------
`define TCAM_SRC_LOCAL    3'h0
`define TCAM_EN_LOCAL     2'h0
`define TCAM_EN_NET1      2'h1
`define TCAM_EN_NET2      2'h2
`define TCAM_CTRL_RST     2'h0
`define TCAM_CLK_RST      8'h00
`define TCAM_MASK_RST     48'h000000000000

`endif

// file: core/tcam_prio_enc.v
// Priority encoder over the per-entry hit vector.
// Assumes a purely combinational hit vector from the same clock domain.
`timescale 1ns/1ns
`default_nettype none
`include "tcam_map.vh"

module tcam_prio_enc (
	// Hit vector, bit i set when entry i matches
	input  wire [`TCAM_ENTRIES-1:0] hit,
	// Encoded result
	output reg                      any_hit,
	output reg                      multi_hit,
	output reg  [`TCAM_AW-1:0]      low_addr
);

	// ------------------------------------------------------------------
	// Encoding
	// ------------------------------------------------------------------

	integer i;

	// Scan from the top so the smallest index wins last
	always @* begin
		any_hit   = 1'b0;
		multi_hit = 1'b0;
		low_addr  = {`TCAM_AW{1'b0}};
		for (i = `TCAM_ENTRIES - 1; i >= 0; i = i - 1) begin
			if (hit[i]) begin
				low_addr = i[`TCAM_AW-1:0];
			end
		end
		for (i = 0; i < `TCAM_ENTRIES; i = i + 1) begin
			if (hit[i]) begin
				multi_hit = multi_hit | any_hit;
				any_hit   = 1'b1;
			end
		end
	end

endmodule
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking testbench for the ternary match block.
// Assumes the design header is on the include path.
`timescale 1ns/1ns
`default_nettype none
`include "tcam_map.vh"

module tb_top;
	logic        core_clk          = 1'b0;
	logic        rst_n             = 1'b0;
	logic [3:0]  global_clock_nets = 4'h2;
	logic        loc_rst           = 1'b0;
	logic [7:0]  reg_addr          = 8'h00;
	logic [31:0] reg_wdata         = 32'h0;
	logic        reg_wr            = 1'b0;
	logic        reg_rd            = 1'b0;
	logic [31:0] rd;
	wire  [47:0] cmp_wr_data;
	wire  [6:0]  wr_addr, match_addr;
	wire         wr_en, wr_sel, dont_care_wr, mask_en;
	wire         match_flag, multi_match, match_valid;
	wire  [31:0] reg_rdata;
	int          fail_count = 0;
	int          samples_checked = 0;
	localparam logic [47:0] K1 = 48'h1111_2222_3301;
	localparam logic [47:0] K2 = 48'haaaa_bbbb_cc77;
	localparam logic [47:0] K3 = 48'h5555_6666_7788;
	localparam logic [47:0] KD = 48'h0123_4567_8900;

	// 250 MHz clock
	always #2 core_clk = ~core_clk;

	// Far-side user logic and the block
	tcam_user_model i_usr (.core_clk, .cmp_wr_data, .wr_addr, .wr_en,
		.wr_sel, .dont_care_wr, .mask_en);
	tcam_block i_dut (.core_clk, .rst_n, .global_clock_nets, .loc_rst,
		.cmp_wr_data, .wr_addr, .wr_en, .wr_sel, .dont_care_wr, .mask_en,
		.match_flag, .multi_match, .match_addr, .match_valid,
		.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);

	task automatic chk_val(input string n, input logic [47:0] e, g);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask

	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(negedge core_clk);
		rd = reg_rdata;
		@(posedge core_clk);
		chk_val($sformatf("reg %h", a), {16'h0, e}, {16'h0, rd});
	endtask

	// Outputs, then the status register that mirrors them
	task automatic chk_hit(input logic m, mm, input logic [6:0] a);
		@(negedge core_clk);
		chk_val("match outputs", {38'h0, m, m, mm, a},
			{38'h0, match_valid, match_flag, multi_match, match_addr});
		@(posedge core_clk);
		chk_reg(`TCAM_REG_STATUS, {21'h0, m, mm, m, 1'b0, a});
	endtask

	// Key through capture and output stages, then released
	task automatic look(input logic [47:0] k, input logic men,
		input logic m, mm, input logic [6:0] a);
		i_usr.cmp(k, men);
		repeat (3) @(posedge core_clk);
		chk_hit(m, mm, a);
		i_usr.idle();
	endtask

	// Bounded wait for a slow stage to load the address
	task automatic settle(input logic [6:0] a);
		@(negedge core_clk);
		for (int n = 0; n < 12 && match_addr !== a; n++)
			@(negedge core_clk);
		repeat (2) @(posedge core_clk);
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Watchdog, far beyond the few hundred cycles needed
	initial begin
		#20000;
		fail_count++;
		summarize();
	end

	// Test sequence
	initial begin
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		for (int a = 0; a <= 8'h1c; a += 4)
			chk_reg(8'(a), 32'h0);
		reg_write(`TCAM_REG_MASK_HI, 32'hdead_beef);
		chk_reg(`TCAM_REG_MASK_HI, 32'h0000_beef);
		reg_write(`TCAM_REG_MASK_HI, 32'h0);
		$display("test reset_values done");
		reg_write(`TCAM_REG_CTRL, 32'h1);
		reg_write(`TCAM_REG_ICLK, 32'h10);
		chk_reg(`TCAM_REG_ICLK, 32'h10);
		look(48'h0, 1'b0, 1'b1, 1'b1, 7'h00);
		look(K1, 1'b0, 1'b0, 1'b0, 7'h00);
		i_usr.wr(7'h09, K1, 1'b0, 1'b0);
		i_usr.wr(7'h05, K1, 1'b0, 1'b0);
		look(K1, 1'b0, 1'b1, 1'b1, 7'h05);
		i_usr.wr(7'h7f, K2, 1'b0, 1'b0);
		look(K2, 1'b0, 1'b1, 1'b0, 7'h7f);
		$display("test compare done");
		reg_write(`TCAM_REG_MASK_LO, 32'hff);
		chk_reg(`TCAM_REG_MASK_LO, 32'hff);
		i_usr.wr(7'h7f, K3, 1'b0, 1'b1);
		look({K3[47:8], K2[7:0]}, 1'b0, 1'b1, 1'b0, 7'h7f);
		look(K3, 1'b0, 1'b0, 1'b0, 7'h00);
		look({K3[47:8], 8'h5a}, 1'b1, 1'b1, 1'b0, 7'h7f);
		look({K3[47:8], 8'h5a}, 1'b0, 1'b0, 1'b0, 7'h00);
		$display("test mask done");
		i_usr.wr(7'h03, K3, 1'b1, 1'b1);
		look(KD, 1'b0, 1'b1, 1'b0, 7'h03);
		look(KD | 48'h1, 1'b0, 1'b0, 1'b0, 7'h00);
		$display("test dont_care done");
		i_usr.cmp(K1, 1'b0);
		loc_rst <= 1'b1;
		repeat (3) @(posedge core_clk);
		chk_hit(1'b0, 1'b0, 7'h00);
		loc_rst <= 1'b0;
		repeat (3) @(posedge core_clk);
		chk_hit(1'b1, 1'b1, 7'h05);
		reg_write(`TCAM_REG_CTRL, 32'h3);
		repeat (3) @(posedge core_clk);
		chk_hit(1'b0, 1'b0, 7'h00);
		loc_rst <= 1'b1;
		repeat (3) @(posedge core_clk);
		chk_hit(1'b1, 1'b1, 7'h05);
		loc_rst <= 1'b0;
		reg_write(`TCAM_REG_CTRL, 32'h1);
		i_usr.idle();
		$display("test local_reset done");
		reg_write(`TCAM_REG_ICLK, 32'h11);
		i_usr.cmp(KD, 1'b0);
		repeat (6) @(posedge core_clk);
		chk_hit(1'b0, 1'b0, 7'h00);
		global_clock_nets[0] <= 1'b1;
		settle(7'h03);
		chk_hit(1'b1, 1'b0, 7'h03);
		global_clock_nets[0] <= 1'b0;
		reg_write(`TCAM_REG_ICLK, 32'h10);
		i_usr.idle();
		$display("test input_clock done");
		repeat (4) @(posedge core_clk);
		reg_write(`TCAM_REG_CTRL, 32'h0);
		reg_write(`TCAM_REG_OCLK, 32'h20);
		look(K1, 1'b0, 1'b0, 1'b0, 7'h00);
		i_usr.cmp(K1, 1'b0);
		global_clock_nets[2] <= 1'b1;
		settle(7'h05);
		chk_hit(1'b1, 1'b1, 7'h05);
		i_usr.idle();
		$display("test output_clock done");
		summarize();
	end
endmodule
`default_nettype wire

// file: tb/tcam_block_properties.sv
// Concurrent checks on the ternary match block's ports.
// Assumes it is bound to tcam_block and sees nothing but its ports.
`timescale 1ns/1ns
`default_nettype none
`include "tcam_map.vh"

module tcam_chk (
	// Clock and reset
	input wire logic        core_clk,
	input wire logic        rst_n,
	// Match outputs
	input wire logic        match_flag,
	input wire logic        multi_match,
	input wire logic [6:0]  match_addr,
	input wire logic        match_valid,
	// Register port
	input wire logic [7:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	// Mask word written, then read back after one idle cycle
	sequence s_mask_wr;
		reg_wr && reg_addr == `TCAM_REG_MASK_LO;
	endsequence
	sequence s_mask_rd;
		reg_rd && reg_addr == `TCAM_REG_MASK_LO;
	endsequence

	// Output relations
	a_valid_is_match: assert property (match_valid == match_flag)
		else $error("match_valid differs from match_flag");
	a_multi_needs_match: assert property (multi_match |-> match_flag)
		else $error("multi_match without match_flag");
	a_miss_addr_zero: assert property (!match_flag |-> !match_addr)
		else $error("match_addr not zero on a miss");
	a_reset_quiet: assert property ($rose(rst_n) |->
		(!match_flag && !multi_match) [*3])
		else $error("flags set right after reset");
	// Register port relations
	a_rdata_one_cycle: assert property (!reg_rd |=> reg_rdata == 32'h0)
		else $error("read data outside its cycle");
	a_unmapped_zero: assert property (
		reg_rd && reg_addr == 8'h1c |=> reg_rdata == 32'h0)
		else $error("unmapped read not zero");
	a_mask_readback: assert property (
		s_mask_wr ##2 s_mask_rd |=> reg_rdata == $past(reg_wdata, 3))
		else $error("mask word read back wrong");
	a_status_mirror: assert property (
		reg_rd && reg_addr == `TCAM_REG_STATUS |=> reg_rdata[10:0] ==
		{$past(match_valid), $past(multi_match), $past(match_flag),
		1'b0, $past(match_addr)})
		else $error("status read differs from outputs");
endmodule

bind tcam_block tcam_chk i_chk (
	.core_clk, .rst_n, .match_flag, .multi_match, .match_addr,
	.match_valid, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata
);
`default_nettype wire

// file: tb/tcam_user_model.sv
// Model of the user logic that feeds the match block's data inputs.
// Assumes a shared core_clk; tasks are entered just after a rising edge.
`timescale 1ns/1ns
`default_nettype none

module tcam_user_model (
	// Clock
	input  wire logic        core_clk,
	// Data path towards the block
	output var  logic [47:0] cmp_wr_data,
	output var  logic [6:0]  wr_addr,
	output var  logic        wr_en,
	output var  logic        wr_sel,
	output var  logic        dont_care_wr,
	output var  logic        mask_en
);
	// Quiet start
	initial begin
		{cmp_wr_data, wr_addr, wr_en, wr_sel, dont_care_wr, mask_en} <= '0;
	end

	// Release select; data shows the inverse of its last value
	task automatic idle();
		wr_sel       <= 1'b0;
		wr_en        <= 1'b0;
		dont_care_wr <= 1'b0;
		mask_en      <= 1'b0;
		cmp_wr_data  <= ~cmp_wr_data;
		@(posedge core_clk);
	endtask

	// Present a search key, held until idle
	task automatic cmp(input logic [47:0] key, input logic men);
		cmp_wr_data <= key;
		wr_en       <= 1'b0;
		wr_sel      <= 1'b1;
		mask_en     <= men;
	endtask

	// One write; mask enable held over capture and update edges
	task automatic wr(input logic [6:0] a, input logic [47:0] d,
		input logic dc, input logic men);
		cmp_wr_data  <= d;
		wr_addr      <= a;
		wr_en        <= 1'b1;
		wr_sel       <= 1'b1;
		dont_care_wr <= dc;
		mask_en      <= men;
		@(posedge core_clk);
		wr_sel <= 1'b0;
		wr_en  <= 1'b0;
		@(posedge core_clk);
		idle();
	endtask
endmodule
`default_nettype wire
